// *** core/msm_regs.svh ***
// Shared constants for the module select management port
`ifndef MSM_REGS_SVH
`define MSM_REGS_SVH
// ----------------------------------------
// Clock and link timing
// ----------------------------------------
`define MSM_CLK_PERIOD_NS 25
`define MSM_CLK_KHZ 40000
`define MSM_SCL_KHZ 400
`define MSM_PHASES_PER_BIT 4
`define MSM_RESET_MIN_NS 10000
`define MSM_SEL_ASSERT_NS 2000
`define MSM_SEL_DEASSERT_NS 2000
// ----------------------------------------
// Two-wire framing and memory layout
// ----------------------------------------
`define MSM_DEV_ADDR 7'h50
`define MSM_RD_BIT 1'b1
`define MSM_WR_BIT 1'b0
`define MSM_BITS_PER_BYTE 4'h8
`define MSM_FLAGS_IDX 8'h00
`define MSM_MASK_IDX 8'h01
`define MSM_IDLE_BYTE 8'hFF
`endif

// *** core/msm_pkg.sv ***
// Types shared by both ends of the management port
package msm_pkg;
	typedef enum logic [2:0] {
		DS_IDLE, DS_ADDR, DS_ACK_ADDR, DS_WRITE, DS_ACK_WR, DS_READ, DS_RACK, DS_IGNORE
	} msm_dev_state_e;
	typedef enum logic [2:0] {
		HS_IDLE, HS_SEL_WAIT, HS_START, HS_XFER, HS_STOP, HS_DESEL_WAIT
	} msm_host_state_e;
endpackage

// *** core/msm_link_if.sv ***
// Pins between host board and pluggable module, with wired levels
`timescale 1ns/100ps
interface msm_link_if;
	logic sel_o, sel_oe, rst_o, rst_oe, lp_o, lp_oe;
	logic h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, d_sda_o, d_sda_oe;
	logic prs_o, prs_oe, irq_o, irq_oe;
	logic scl, sda, module_present_n, interrupt_request_n;
	// ----------------------------------------
	// Host board pull-ups on shared lines
	// ----------------------------------------
	assign scl = ~(h_scl_oe & ~h_scl_o);
	assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
	assign module_present_n = prs_oe ? prs_o : 1'b1;
	assign interrupt_request_n = irq_oe ? irq_o : 1'b1;
	modport host_end (
		output sel_o, sel_oe, rst_o, rst_oe, lp_o, lp_oe, h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
		input scl, sda, module_present_n, interrupt_request_n
	);
	modport module_end (
		input sel_o, sel_oe, rst_o, rst_oe, lp_o, lp_oe, scl, sda,
		output d_sda_o, d_sda_oe, prs_o, prs_oe, irq_o, irq_oe
	);
endinterface

// *** core/msm_module_end.sv ***
// Module end: select-gated two-wire slave, sideband pins, interrupt
`timescale 1ns/100ps
`include "msm_regs.svh"
module msm_module_end #(
	parameter int MEM_DEPTH = 8,
	parameter logic [6:0] DEV_ADDR = `MSM_DEV_ADDR,
	parameter int RESET_MIN_CYC = (`MSM_RESET_MIN_NS + `MSM_CLK_PERIOD_NS - 1) / `MSM_CLK_PERIOD_NS
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	msm_link_if.module_end link,
	input wire logic [7:0] event_i,
	output logic low_power_o,
	output logic in_reset_o,
	output logic selected_o,
	output logic [7:0] flags_o
);
	import msm_pkg::*;
	localparam int IW = $clog2(MEM_DEPTH);
	localparam int RW = $clog2(RESET_MIN_CYC + 1);
	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic [1:0] sel_sync;
		logic [1:0] rst_sync;
		logic [1:0] lp_sync;
		logic scl_q;
		logic sda_q;
		logic [RW-1:0] rst_cnt;
		logic rst_hold;
		msm_dev_state_e st;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] tx;
		logic rw;
		logic first;
		logic nack;
		logic sda_drv;
		logic [7:0] ptr;
		logic [7:0] flags;
		logic irq;
		logic [MEM_DEPTH-1:0][7:0] mem;
	} msm_dev_s;
	msm_dev_s s;
	msm_dev_s next_s;
	logic scl, sda, sel, start, stop, rise, fall;
	logic [7:0] clr;
	logic [7:0] rbyte;

	// ----------------------------------------
	// Pin helpers
	// ----------------------------------------
	// Module-side pull-up: an undriven input reads high
	function automatic logic pulled_up(input logic out, input logic oe);
		return oe ? out : 1'b1;
	endfunction

	function automatic logic [7:0] read_byte(input msm_dev_s v);
		if (v.ptr == `MSM_FLAGS_IDX) begin
			return v.flags;
		end
		return v.mem[v.ptr[IW-1:0]];
	endfunction

	assign scl = s.scl_sync[1];
	assign sda = s.sda_sync[1];
	assign sel = ~s.sel_sync[1];
	assign start = scl & s.scl_q & s.sda_q & ~sda;
	assign stop = scl & s.scl_q & ~s.sda_q & sda;
	assign rise = scl & ~s.scl_q;
	assign fall = ~scl & s.scl_q;
	assign rbyte = read_byte(s);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		clr = 8'h00;
		next_s.scl_sync = {s.scl_sync[0], link.scl};
		next_s.sda_sync = {s.sda_sync[0], link.sda};
		next_s.sel_sync = {s.sel_sync[0], pulled_up(link.sel_o, link.sel_oe)};
		next_s.rst_sync = {s.rst_sync[0], pulled_up(link.rst_o, link.rst_oe)};
		next_s.lp_sync = {s.lp_sync[0], pulled_up(link.lp_o, link.lp_oe)};
		next_s.scl_q = scl;
		next_s.sda_q = sda;
		// Short glitches on the reset pin are filtered by the length count
		if (s.rst_sync[1]) begin
			next_s.rst_cnt = '0;
			next_s.rst_hold = 1'b0;
		end else if (s.rst_cnt == RW'(RESET_MIN_CYC)) begin
			next_s.rst_hold = 1'b1;
		end else begin
			next_s.rst_cnt = s.rst_cnt + RW'(1);
		end
		if (s.rst_hold) begin
			next_s.st = DS_IDLE;
			next_s.cnt = 4'h0;
			next_s.shreg = 8'h00;
			next_s.tx = 8'h00;
			next_s.rw = 1'b0;
			next_s.first = 1'b0;
			next_s.nack = 1'b0;
			next_s.sda_drv = 1'b0;
			next_s.ptr = 8'h00;
			next_s.flags = 8'h00;
			next_s.mem = '0;
		end else begin
			if (start) begin
				next_s.cnt = 4'h0;
				next_s.sda_drv = 1'b0;
				next_s.first = 1'b1;
				next_s.st = sel ? DS_ADDR : DS_IGNORE;
			end else if (stop) begin
				next_s.sda_drv = 1'b0;
				next_s.st = DS_IDLE;
			end else if (!sel) begin
				next_s.sda_drv = 1'b0;
				if (s.st != DS_IDLE) begin
					next_s.st = DS_IGNORE;
				end
			end else begin
				// Slave only: SCL is never driven from this end
				unique case (s.st)
					DS_IDLE, DS_IGNORE: begin
					end
					DS_ADDR, DS_WRITE: begin
						if (rise) begin
							next_s.shreg = {s.shreg[6:0], sda};
							next_s.cnt = s.cnt + 4'h1;
						end else if (fall && s.cnt == `MSM_BITS_PER_BYTE) begin
							next_s.cnt = 4'h0;
							if (s.st == DS_ADDR) begin
								if (s.shreg[7:1] == DEV_ADDR) begin
									next_s.rw = s.shreg[0];
									next_s.sda_drv = 1'b1;
									next_s.st = DS_ACK_ADDR;
								end else begin
									next_s.st = DS_IGNORE;
								end
							end else begin
								if (s.first) begin
									next_s.ptr = s.shreg;
									next_s.first = 1'b0;
								end else begin
									if (s.ptr != `MSM_FLAGS_IDX) begin
										next_s.mem[s.ptr[IW-1:0]] = s.shreg;
									end
									next_s.ptr = s.ptr + 8'h01;
								end
								next_s.sda_drv = 1'b1;
								next_s.st = DS_ACK_WR;
							end
						end
					end
					DS_ACK_ADDR: begin
						if (fall) begin
							if (s.rw == `MSM_RD_BIT) begin
								next_s.tx = rbyte;
								next_s.sda_drv = ~rbyte[7];
								next_s.ptr = s.ptr + 8'h01;
								clr = (s.ptr == `MSM_FLAGS_IDX) ? rbyte : 8'h00;
								next_s.st = DS_READ;
							end else begin
								next_s.sda_drv = 1'b0;
								next_s.st = DS_WRITE;
							end
						end
					end
					DS_ACK_WR: begin
						if (fall) begin
							next_s.sda_drv = 1'b0;
							next_s.st = DS_WRITE;
						end
					end
					DS_READ: begin
						if (rise) begin
							next_s.cnt = s.cnt + 4'h1;
						end else if (fall) begin
							if (s.cnt == `MSM_BITS_PER_BYTE) begin
								next_s.sda_drv = 1'b0;
								next_s.cnt = 4'h0;
								next_s.st = DS_RACK;
							end else begin
								next_s.tx = {s.tx[6:0], 1'b1};
								next_s.sda_drv = ~s.tx[6];
							end
						end
					end
					DS_RACK: begin
						if (rise) begin
							next_s.nack = sda;
						end else if (fall) begin
							if (s.nack) begin
								next_s.st = DS_IGNORE;
							end else begin
								next_s.tx = rbyte;
								next_s.sda_drv = ~rbyte[7];
								next_s.ptr = s.ptr + 8'h01;
								clr = (s.ptr == `MSM_FLAGS_IDX) ? rbyte : 8'h00;
								next_s.st = DS_READ;
							end
						end
					end
				endcase
			end
			// Clear on read, but an event in the same cycle survives
			next_s.flags = (s.flags & ~clr) | event_i;
		end
		next_s.irq = |(next_s.flags & ~next_s.mem[`MSM_MASK_IDX]);
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= '0;
			s.scl_sync <= 2'b11;
			s.sda_sync <= 2'b11;
			s.sel_sync <= 2'b11;
			s.rst_sync <= 2'b11;
			s.lp_sync <= 2'b11;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Pins and user outputs
	// ----------------------------------------
	assign link.d_sda_o = 1'b0;
	assign link.d_sda_oe = s.sda_drv & sel;
	assign link.prs_o = 1'b0;
	assign link.prs_oe = 1'b1;
	assign link.irq_o = 1'b0;
	assign link.irq_oe = s.irq;
	assign low_power_o = s.lp_sync[1];
	assign in_reset_o = s.rst_hold;
	assign selected_o = sel;
	assign flags_o = s.flags;
endmodule

// *** core/msm_host_end.sv ***
// Host end: select sequencing, sideband drive, two-wire master
`timescale 1ns/100ps
`include "msm_regs.svh"
module msm_host_end #(
	parameter logic [6:0] DEV_ADDR = `MSM_DEV_ADDR,
	parameter int QTR_CYC = `MSM_CLK_KHZ / (`MSM_SCL_KHZ * `MSM_PHASES_PER_BIT),
	parameter int SEL_ASSERT_CYC = (`MSM_SEL_ASSERT_NS + `MSM_CLK_PERIOD_NS - 1) / `MSM_CLK_PERIOD_NS,
	parameter int SEL_DEASSERT_CYC = (`MSM_SEL_DEASSERT_NS + `MSM_CLK_PERIOD_NS - 1) / `MSM_CLK_PERIOD_NS
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	msm_link_if.host_end link,
	input wire logic req_i,
	input wire logic rw_i,
	input wire logic [7:0] ptr_i,
	input wire logic [7:0] wdata_i,
	input wire logic module_reset_n_i,
	input wire logic low_power_request_i,
	output logic busy_o,
	output logic done_o,
	output logic nack_o,
	output logic [7:0] rdata_o,
	output logic present_o,
	output logic irq_o
);
	import msm_pkg::*;
	localparam int QW = $clog2(QTR_CYC + 1);
	localparam int WW = $clog2(SEL_ASSERT_CYC + SEL_DEASSERT_CYC + 1);
	typedef struct packed {
		logic [1:0] sda_sync;
		logic [1:0] prs_sync;
		logic [1:0] irq_sync;
		msm_host_state_e st;
		logic [QW-1:0] qcnt;
		logic [WW-1:0] wcnt;
		logic [1:0] ph;
		logic [3:0] bcnt;
		logic [1:0] bidx;
		logic again;
		logic [8:0] tx;
		logic [8:0] rx;
		logic scl;
		logic sda;
		logic sel_n;
		logic rst_n;
		logic lp;
		logic rw;
		logic [7:0] ptr;
		logic [7:0] wdata;
		logic done;
		logic nack;
		logic [7:0] rdata;
	} msm_host_s;
	msm_host_s s;
	msm_host_s next_s;
	logic tick;

	// Byte sequence: write = addr+W, ptr, data; read = addr+W, ptr, stop, addr+R, data
	function automatic logic [8:0] seq_byte(input msm_host_s v);
		logic [7:0] b;
		b = `MSM_IDLE_BYTE;
		unique case (v.bidx)
			2'd0: b = {DEV_ADDR, `MSM_WR_BIT};
			2'd1: b = v.ptr;
			2'd2: b = v.rw ? {DEV_ADDR, `MSM_RD_BIT} : v.wdata;
			2'd3: b = `MSM_IDLE_BYTE;
		endcase
		return {b, 1'b1};
	endfunction

	assign tick = (s.qcnt == QW'(QTR_CYC - 1));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.sda_sync = {s.sda_sync[0], link.sda};
		next_s.prs_sync = {s.prs_sync[0], link.module_present_n};
		next_s.irq_sync = {s.irq_sync[0], link.interrupt_request_n};
		next_s.qcnt = tick ? '0 : s.qcnt + QW'(1);
		next_s.rst_n = module_reset_n_i;
		next_s.lp = low_power_request_i;
		next_s.done = 1'b0;
		if (tick) begin
			next_s.ph = s.ph + 2'd1;
		end
		unique case (s.st)
			HS_IDLE: begin
				if (req_i) begin
					next_s.rw = rw_i;
					next_s.ptr = ptr_i;
					next_s.wdata = wdata_i;
					next_s.nack = 1'b0;
					next_s.bidx = 2'd0;
					next_s.again = 1'b0;
					next_s.sel_n = 1'b0;
					next_s.wcnt = '0;
					next_s.st = HS_SEL_WAIT;
				end
			end
			HS_SEL_WAIT: begin
				next_s.wcnt = s.wcnt + WW'(1);
				next_s.ph = 2'd0;
				if (s.wcnt == WW'(SEL_ASSERT_CYC - 1)) begin
					next_s.st = HS_START;
				end
			end
			HS_START: begin
				if (tick) begin
					unique case (s.ph)
						2'd0: begin
							next_s.sda = 1'b1;
							next_s.scl = 1'b1;
						end
						2'd1: next_s.sda = 1'b0;
						2'd2: next_s.scl = 1'b0;
						2'd3: begin
							next_s.tx = seq_byte(s);
							next_s.bcnt = 4'h0;
							next_s.st = HS_XFER;
						end
					endcase
				end
			end
			HS_XFER: begin
				if (tick) begin
					unique case (s.ph)
						2'd0: next_s.sda = s.tx[8];
						2'd1: next_s.scl = 1'b1;
						2'd2: next_s.rx = {s.rx[7:0], s.sda_sync[1]};
						2'd3: begin
							next_s.scl = 1'b0;
							next_s.tx = {s.tx[7:0], 1'b1};
							next_s.bcnt = s.bcnt + 4'h1;
							if (s.bcnt == `MSM_BITS_PER_BYTE) begin
								next_s.bcnt = 4'h0;
								if (s.bidx == 2'd3) begin
									next_s.rdata = s.rx[8:1];
									next_s.st = HS_STOP;
								end else if (s.rx[0]) begin
									next_s.nack = 1'b1;
									next_s.st = HS_STOP;
								end else if ((s.bidx == 2'd1 && s.rw) || (s.bidx == 2'd2 && !s.rw)) begin
									// Read turns round after the pointer, write stops after its data
									next_s.again = s.rw && s.bidx == 2'd1;
									next_s.bidx = s.bidx + 2'd1;
									next_s.st = HS_STOP;
								end else begin
									next_s.bidx = s.bidx + 2'd1;
									next_s.tx = seq_byte(next_s);
								end
							end
						end
					endcase
				end
			end
			HS_STOP: begin
				if (tick) begin
					unique case (s.ph)
						2'd0: next_s.sda = 1'b0;
						2'd1: next_s.scl = 1'b1;
						2'd2: next_s.sda = 1'b1;
						2'd3: begin
							next_s.again = 1'b0;
							if (s.again) begin
								next_s.st = HS_START;
							end else begin
								next_s.sel_n = 1'b1;
								next_s.wcnt = '0;
								next_s.st = HS_DESEL_WAIT;
							end
						end
					endcase
				end
			end
			HS_DESEL_WAIT: begin
				next_s.wcnt = s.wcnt + WW'(1);
				// No new traffic until the deselect time has run out
				if (s.wcnt == WW'(SEL_DEASSERT_CYC - 1)) begin
					next_s.done = 1'b1;
					next_s.st = HS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= '0;
			s.sda_sync <= 2'b11;
			s.prs_sync <= 2'b11;
			s.irq_sync <= 2'b11;
			s.scl <= 1'b1;
			s.sda <= 1'b1;
			s.sel_n <= 1'b1;
			s.rst_n <= 1'b1;
			s.lp <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Pins and user outputs
	// ----------------------------------------
	assign link.sel_o = s.sel_n;
	assign link.sel_oe = 1'b1;
	assign link.rst_o = s.rst_n;
	assign link.rst_oe = 1'b1;
	assign link.lp_o = s.lp;
	assign link.lp_oe = 1'b1;
	assign link.h_scl_o = 1'b0;
	assign link.h_scl_oe = ~s.scl;
	assign link.h_sda_o = 1'b0;
	assign link.h_sda_oe = ~s.sda;
	assign busy_o = (s.st != HS_IDLE);
	assign done_o = s.done;
	assign nack_o = s.nack;
	assign rdata_o = s.rdata;
	assign present_o = ~s.prs_sync[1];
	assign irq_o = ~s.irq_sync[1];
endmodule

// *** test/msm_link_assertions.sv ***
// Concurrent checks on the pins between host board and module
`timescale 1ns/100ps
module msm_link_assertions #(
	parameter int RESET_MIN_CYC = 400
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic sel_o,
	input wire logic sel_oe,
	input wire logic rst_o,
	input wire logic rst_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic d_sda_o,
	input wire logic d_sda_oe,
	input wire logic prs_o,
	input wire logic prs_oe,
	input wire logic irq_o,
	input wire logic irq_oe,
	input wire logic module_present_n,
	input wire logic interrupt_request_n
);
	int rst_low;
	// ----------------------------------------
	// Cycles the pin reset has been held low
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_low <= 0;
		end else if (rst_oe && !rst_o) begin
			rst_low <= (rst_low > 100000) ? rst_low : rst_low + 1;
		end else begin
			rst_low <= 0;
		end
	end
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	// ----------------------------------------
	// Module side
	// ----------------------------------------
	sel_gate_a: assert property (d_sda_oe |-> (sel_oe && !sel_o))
		else $error("data driven while deselected");
	undriven_sel_a: assert property (!sel_oe |-> !d_sda_oe)
		else $error("floating select treated as selected");
	present_low_a: assert property (prs_oe && !prs_o && !module_present_n)
		else $error("presence not held low");
	irq_open_drain_a: assert property (irq_oe |-> (!irq_o && !interrupt_request_n))
		else $error("interrupt not open drain");
	sda_release_a: assert property (d_sda_oe |-> !d_sda_o)
		else $error("data line driven high");
	// Ack and read data may only move while the clock is low
	slave_only_a: assert property ((scl && $past(scl) && $stable(sel_o)) |-> $stable(d_sda_oe))
		else $error("module moved data with clock high");
	reset_hold_a: assert property ((rst_low > RESET_MIN_CYC + 8) |-> !irq_oe)
		else $error("interrupt kept through long reset");
	// ----------------------------------------
	// Host side waits, with select times of 4
	// ----------------------------------------
	assert_wait_a: assert property ($fell(sel_o) |-> (scl && sda) [*4])
		else $error("traffic too soon after select");
	deassert_wait_a: assert property ($rose(sel_o) |-> (scl && sda) [*4])
		else $error("traffic too soon after deselect");
	cover property (d_sda_oe);
	cover property ($rose(irq_oe));
	cover property (rst_low > RESET_MIN_CYC + 8);
endmodule

// *** test/module_select_mgmt_port_tb_top.sv ***
// Bench: host end against module end, and a hand-driven host on a second link
`timescale 1ns/100ps
`include "msm_regs.svh"
module module_select_mgmt_port_tb_top;
	localparam int RST_MIN = 4;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic req_i = 1'b0, rw_i = 1'b0, module_reset_n_i = 1'b1, low_power_request_i = 1'b1;
	logic [7:0] ptr_i = 8'h00, wdata_i = 8'h00, event_i = 8'h00, rdata_o, flags_o, shreg;
	logic busy_o, done_o, nack_o, present_o, irq_o, low_power_o, in_reset_o, selected_o;
	logic lp2, inr2, sel2, ack;
	int mismatches = 0, comparisons = 0, nbits = 0;
	msm_link_if lk();
	msm_link_if lk2();
	always #12.5 clock_i = ~clock_i;
	msm_host_end #(.QTR_CYC(8), .SEL_ASSERT_CYC(4), .SEL_DEASSERT_CYC(4)) msm_host_end_inst (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .link(lk), .req_i(req_i), .rw_i(rw_i), .ptr_i(ptr_i),
		.wdata_i(wdata_i), .module_reset_n_i(module_reset_n_i), .low_power_request_i(low_power_request_i),
		.busy_o(busy_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o), .present_o(present_o), .irq_o(irq_o));
	msm_module_end #(.RESET_MIN_CYC(RST_MIN)) msm_module_end_inst (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .link(lk), .event_i(event_i), .low_power_o(low_power_o),
		.in_reset_o(in_reset_o), .selected_o(selected_o), .flags_o(flags_o));
	msm_module_end #(.RESET_MIN_CYC(RST_MIN)) msm_module_end_inst2 (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .link(lk2), .event_i(8'h00), .low_power_o(lp2),
		.in_reset_o(inr2), .selected_o(sel2), .flags_o());
	msm_link_assertions #(.RESET_MIN_CYC(RST_MIN)) msm_link_assertions_inst (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .sel_o(lk.sel_o), .sel_oe(lk.sel_oe), .rst_o(lk.rst_o),
		.rst_oe(lk.rst_oe), .scl(lk.scl), .sda(lk.sda), .d_sda_o(lk.d_sda_o), .d_sda_oe(lk.d_sda_oe),
		.prs_o(lk.prs_o), .prs_oe(lk.prs_oe), .irq_o(lk.irq_o), .irq_oe(lk.irq_oe),
		.module_present_n(lk.module_present_n), .interrupt_request_n(lk.interrupt_request_n));
	// ----------------------------------------
	// First eight bits after each START on the joined link
	// ----------------------------------------
	always @(negedge lk.sda) if (lk.scl) nbits = 0;
	always @(posedge lk.scl) begin
		if (nbits < 8) shreg = {shreg[6:0], lk.sda};
		nbits = nbits + 1;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic xfer(input logic rw, input logic [7:0] ptr, input logic [7:0] wd);
		int i;
		req_i <= 1'b1;
		rw_i <= rw;
		ptr_i <= ptr;
		wdata_i <= wd;
		cycles(1);
		req_i <= 1'b0;
		cycles(8);
		check({6'h00, busy_o, selected_o}, 8'h03);
		for (i = 0; i < 5000; i++) begin
			@(posedge clock_i);
			if (done_o === 1'b1) break;
		end
		if (i == 5000) begin
			mismatches++;
			results();
		end
		check({6'h00, busy_o, selected_o}, 8'h00);
		check({7'h00, nack_o}, 8'h00);
		check(shreg, {`MSM_DEV_ADDR, rw});
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
		xfer(`MSM_RD_BIT, ptr, 8'h00);
		check(rdata_o, exp);
	endtask
	// One third of a hand-driven bit: open-drain pulls, then hold
	task automatic ph(input logic scl_low, input logic sda_low);
		lk2.h_scl_oe <= scl_low;
		lk2.h_sda_oe <= sda_low;
		cycles(8);
	endtask
	// Address frame on the second link; select may flip after START
	task automatic frame(input logic s_oe, input logic s_start, input logic s_after, output logic acked);
		logic [7:0] b;
		b = {`MSM_DEV_ADDR, `MSM_WR_BIT};
		lk2.sel_oe <= s_oe;
		lk2.sel_o <= s_start;
		cycles(16);
		ph(1'b0, 1'b1);
		lk2.sel_o <= s_after;
		ph(1'b1, 1'b1);
		for (int k = 7; k >= 0; k--) begin
			ph(1'b1, !b[k]);
			ph(1'b0, !b[k]);
			ph(1'b1, !b[k]);
		end
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
		acked = !lk2.sda;
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
		ph(1'b0, 1'b1);
		ph(1'b0, 1'b0);
		lk2.sel_o <= 1'b1;
		// Deselect time passes before the next frame may select again
		cycles(8);
	endtask
	initial begin
		// Sideband pins left floating with low drive values behind them
		lk2.sel_o = 1'b0;
		lk2.sel_oe = 1'b0;
		lk2.rst_o = 1'b0;
		lk2.rst_oe = 1'b0;
		lk2.lp_o = 1'b0;
		lk2.lp_oe = 1'b0;
		lk2.h_scl_o = 1'b0;
		lk2.h_scl_oe = 1'b0;
		lk2.h_sda_o = 1'b0;
		lk2.h_sda_oe = 1'b0;
		cycles(8);
		reset_n_i <= 1'b1;
		cycles(10);
		check({4'h0, lk.scl, lk.sda, lk.module_present_n, lk.interrupt_request_n}, 8'h0D);
		check({6'h00, present_o, irq_o}, 8'h02);
		check({5'h00, lp2, inr2, sel2}, 8'h04);
		check({7'h00, low_power_o}, 8'h01);
		low_power_request_i <= 1'b0;
		cycles(8);
		check({7'h00, low_power_o}, 8'h00);
		for (int i = 2; i < 8; i++) xfer(`MSM_WR_BIT, 8'(i), 8'(i * 27));
		for (int i = 2; i < 8; i++) rd(8'(i), 8'(i * 27));
		xfer(`MSM_WR_BIT, `MSM_MASK_IDX, 8'h01);
		event_i <= 8'h01;
		cycles(1);
		event_i <= 8'h00;
		cycles(8);
		check({6'h00, irq_o, lk.interrupt_request_n}, 8'h01);
		event_i <= 8'h02;
		cycles(1);
		event_i <= 8'h00;
		cycles(8);
		check({6'h00, irq_o, lk.interrupt_request_n}, 8'h02);
		rd(`MSM_FLAGS_IDX, 8'h03);
		cycles(8);
		check({7'h00, irq_o}, 8'h00);
		// Pulse shorter than the minimum must leave settings alone
		event_i <= 8'h04;
		module_reset_n_i <= 1'b0;
		cycles(2);
		event_i <= 8'h00;
		module_reset_n_i <= 1'b1;
		cycles(8);
		rd(8'h02, 8'h36);
		module_reset_n_i <= 1'b0;
		cycles(RST_MIN + 12);
		event_i <= 8'h08;
		cycles(1);
		event_i <= 8'h00;
		cycles(4);
		check({flags_o[7:1], in_reset_o}, 8'h01);
		check({7'h00, irq_o}, 8'h00);
		module_reset_n_i <= 1'b1;
		cycles(8);
		check({7'h00, in_reset_o}, 8'h00);
		rd(8'h02, 8'h00);
		rd(`MSM_MASK_IDX, 8'h00);
		frame(1'b0, 1'b0, 1'b0, ack);
		check({7'h00, ack}, 8'h00);
		frame(1'b1, 1'b1, 1'b0, ack);
		check({7'h00, ack}, 8'h00);
		frame(1'b1, 1'b0, 1'b1, ack);
		check({7'h00, ack}, 8'h00);
		frame(1'b1, 1'b0, 1'b0, ack);
		check({7'h00, ack}, 8'h01);
		results();
	end
endmodule
